// ===== bcam_top.sv
// boot configuration loader, bus mode control and address map
//
// Functional notes
// R1: after reset release, read configuration from 2018H before anything else
// R2: configuration read width follows the synchronised width select pin
// R3: configuration bits 7 and 6 are ignored and read as zero
// R4: bits 5:4 pick the ceiling on ready-inserted wait states
// R5: bit 3 picks address latch enable or address valid strobe meaning
// R6: bit 2 picks write plus byte-high or split low/high write strobes
// R7: power-down request takes effect only with bit 0 set
// R8: bit 1 low locks the bus at 8 bits
// R9: bit 1 high lets the width select pin pick 16 or 8 bits
// R10: external circuit holds reset low 16 state times at power-up
// R11: a short later reset makes the device pull reset low 16 state times
// R12: first instruction fetch after configuration goes to 2080h
// R13: 0001AH to 003FFH decodes as on-chip RAM
// R14: 00400H to 1FFFH decodes as external memory
// R15: 02000H to 02013H decodes as lower interrupt vectors
// R16: 02030H to 0203FH upper vectors, 02040H up transfer-server vectors
// R17: 0205EH to 0207FH is reserved and must stay unused
// R18: 02080H to 0FFFFH is external code and data memory
// R19: ready stretches bus cycles; hold hands the bus to another master
// R20: configuration stays latched until the next reset
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module bcam_top
  import bcam_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [7:0]        reg_rdata,
  input  wire logic              reset_pin_n_in,
  output logic                   reset_pin_out,
  output logic                   reset_pin_oe,
  input  wire logic              width_select_pin,
  input  wire logic              ready_pin,
  input  wire logic              hold_pin,
  output logic                   cfg_rd_req,
  output logic      [15:0]       cfg_rd_addr,
  output logic                   cfg_rd_wide,
  input  wire logic              cfg_rd_ack,
  input  wire logic [15:0]       cfg_rd_data,
  output logic                   first_fetch,
  output logic      [15:0]       first_fetch_addr,
  input  wire logic              bus_busy,
  input  wire logic              wait_phase,
  output logic                   cycle_ready,
  output logic                   hold_ack,
  output logic                   bus_16bit,
  output logic                   address_strobe_pin,
  output logic                   write_strobe_split,
  output logic                   power_down_enter,
  output logic                   running,
  input  wire logic [15:0]       cpu_addr,
  output bcam_region_t           addr_region,
  output logic                   addr_external,
  output logic                   addr_reserved
);

  typedef enum logic [2:0] {
    BCAM_ST_FETCH_REQ, BCAM_ST_FETCH_WAIT, BCAM_ST_RUN,
    BCAM_ST_PULLDOWN, BCAM_ST_WAIT_HIGH
  } bcam_state_t;

  typedef struct packed {
    bcam_state_t     state;
    logic [CNT_W-1:0] cnt;
    logic [7:0]      chip_configuration;
    logic            loaded;
    logic            pd_req;
    logic [3:0]      wait_cnt;
    logic [7:0]      rdata;
    logic            pin_oe;
    logic            rd_req;
    logic [15:0]     rd_addr;
    logic            rd_wide;
    logic            ff;
    logic [15:0]     ff_addr;
    logic            ready;
    logic            hold_ack;
    logic            bus16;
    logic            adv;
    logic            split_wr;
    logic            pd_enter;
    logic            run;
    bcam_region_t    region;
    logic            ext;
    logic            rsv;
  } bcam_top_st_t;

  bcam_top_st_t q, d;
  logic         rst_n_s;
  logic         pin_n_s;
  logic         width_s;
  logic         ready_s;
  logic         hold_s;
  logic         pins_ok;
  bcam_region_t region_c;
  logic [3:0]   limit_c;

  // reset release through two flops
  bcam_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk    (clk),
    .resetn (resetn),
    .clk_en (clk_en),
    .din    (1'b1),
    .dout   (rst_n_s)
  );

  // pin inputs from outside the clock domain; the constant one marks a filled pipe
  bcam_sync #(.WIDTH(5), .RST_VAL(1'b0)) u_pin_sync (
    .clk    (clk),
    .resetn (rst_n_s),
    .clk_en (clk_en),
    .din    ({1'b1, reset_pin_n_in, width_select_pin, ready_pin, hold_pin}),
    .dout   ({pins_ok, pin_n_s, width_s, ready_s, hold_s})
  );

  bcam_decode u_decode (
    .addr   (cpu_addr),
    .region (region_c)
  );

  // wait-state ceiling from the ready-mode field
  always_comb begin
    case (q.chip_configuration[CCR_IRC_HI:CCR_IRC_LO])   // [R4]
      2'h0:    limit_c = RDY_LIMIT0;
      2'h1:    limit_c = RDY_LIMIT1;
      2'h2:    limit_c = RDY_LIMIT2;
      default: limit_c = RDY_LIMIT3;
    endcase
  end

  // next-state logic
  always_comb begin
    d = q;
    if (clk_en) begin
      d.ff     = 1'b0;
      d.rd_req = 1'b0;
      // boot sequence
      case (q.state)
        BCAM_ST_FETCH_REQ: begin
          // width pin only trusted once the synchroniser holds real levels
          if (pins_ok) begin
            d.rd_req  = 1'b1;                     // [R1]
            d.rd_addr = CFG_BYTE_ADDR;            // [R1]
            d.rd_wide = width_s;                  // [R2]
            d.state   = BCAM_ST_FETCH_WAIT;
          end
        end
        BCAM_ST_FETCH_WAIT: begin
          d.rd_req = ~cfg_rd_ack;
          if (cfg_rd_ack) begin
            d.chip_configuration     = cfg_rd_data[7:0] & CCR_USED_MASK;   // [R3] [R20]
            d.loaded  = 1'b1;
            d.ff      = 1'b1;                     // [R12]
            d.ff_addr = FIRST_FETCH_ADDR;         // [R12]
            d.state   = BCAM_ST_RUN;
          end
        end
        BCAM_ST_RUN: begin
          if (!pin_n_s) begin
            d.pin_oe = 1'b1;                      // [R11]
            d.cnt    = CNT_W'(PULLDOWN_CYCLES - 1);
            d.state  = BCAM_ST_PULLDOWN;
          end
        end
        BCAM_ST_PULLDOWN: begin
          if (q.cnt == '0) begin
            d.pin_oe = 1'b0;
            d.state  = BCAM_ST_WAIT_HIGH;
          end else begin
            d.cnt = q.cnt - CNT_W'(1);            // [R11]
          end
        end
        BCAM_ST_WAIT_HIGH: begin
          if (pin_n_s) begin
            d.state = BCAM_ST_FETCH_REQ;          // [R1]
          end
        end
        default: begin
          d.state = BCAM_ST_FETCH_REQ;
        end
      endcase
      d.run = (d.state == BCAM_ST_RUN);

      // bus mode outputs from the latched configuration
      d.bus16    = q.chip_configuration[CCR_DYN_BIT] & width_s;  // [R8] [R9]
      d.adv      = q.chip_configuration[CCR_ADV_BIT];            // [R5]
      d.split_wr = q.chip_configuration[CCR_WR_BIT];             // [R6]
      d.pd_enter = q.run & q.pd_req & q.chip_configuration[CCR_PD_BIT];   // [R7]

      // ready stretching with internal ceiling
      d.ready = q.run & wait_phase & ~q.ready & (ready_s | (q.wait_cnt >= limit_c));   // [R19]
      if (!wait_phase || d.ready) begin
        d.wait_cnt = '0;
      end else if (q.wait_cnt != 4'hF) begin
        d.wait_cnt = q.wait_cnt + 4'h1;
      end

      // bus hold grant when idle
      if (!hold_s) begin
        d.hold_ack = 1'b0;
      end else if (q.run && !bus_busy) begin
        d.hold_ack = 1'b1;                        // [R19]
      end

      // address map
      d.region = region_c;
      d.ext    = (region_c == BCAM_RGN_EXT_LO) || (region_c == BCAM_RGN_EXT_HI);   // [R14] [R18]
      d.rsv    = (region_c == BCAM_RGN_RSV);     // [R17]

      // register port
      if (reg_we && reg_addr == REG_CONTROL) begin
        d.pd_req = reg_wdata[CTL_PD_REQ];
      end
      d.rdata = 8'h00;
      if (reg_re) begin
        case (reg_addr)
          REG_CHIP_CFG: d.rdata = q.chip_configuration;
          REG_STATUS: begin
            d.rdata[STS_LOADED] = q.loaded;
            d.rdata[STS_BUS16]  = q.bus16;
            d.rdata[STS_HOLD]   = q.hold_ack;
            d.rdata[STS_PD]     = q.pd_enter;
          end
          REG_CONTROL: d.rdata[CTL_PD_REQ] = q.pd_req;
          default:     d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      q          <= '0;
      q.state    <= BCAM_ST_FETCH_REQ;
      q.chip_configuration      <= CCR_RESET;
      q.region   <= BCAM_RGN_SFR;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata          = q.rdata;
  assign reset_pin_out      = 1'b0 & q.pin_oe;
  assign reset_pin_oe       = q.pin_oe;
  assign cfg_rd_req         = q.rd_req;
  assign cfg_rd_addr        = q.rd_addr;
  assign cfg_rd_wide        = q.rd_wide;
  assign first_fetch        = q.ff;
  assign first_fetch_addr   = q.ff_addr;
  assign cycle_ready        = q.ready;
  assign hold_ack           = q.hold_ack;
  assign bus_16bit          = q.bus16;
  assign address_strobe_pin = q.adv;
  assign write_strobe_split = q.split_wr;
  assign power_down_enter   = q.pd_enter;
  assign running            = q.run;
  assign addr_region        = q.region;
  assign addr_external      = q.ext;
  assign addr_reserved      = q.rsv;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  sequence s_cfg_ack;
    clk_en && q.state == BCAM_ST_FETCH_WAIT && cfg_rd_ack;
  endsequence
  sequence s_first_fetch;
    first_fetch && first_fetch_addr == FIRST_FETCH_ADDR;
  endsequence

  property p_cfg_addr;
    cfg_rd_req |-> cfg_rd_addr == CFG_BYTE_ADDR;
  endproperty
  a_cfg_addr: assert property (p_cfg_addr) else $error("config read address wrong"); // [R1]

  property p_first_fetch;
    s_cfg_ack |=> s_first_fetch ##1 running;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("first fetch missing"); // [R12]

  property p_ignore_hi;
    reg_re && reg_addr == REG_CHIP_CFG |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_ignore_hi: assert property (p_ignore_hi) else $error("bits 7:6 not ignored"); // [R3]

  property p_width_lock;
    clk_en && !q.chip_configuration[CCR_DYN_BIT] |=> !bus_16bit;
  endproperty
  a_width_lock: assert property (p_width_lock) else $error("bus not locked at 8 bits"); // [R8]

  property p_width_dyn;
    clk_en && q.chip_configuration[CCR_DYN_BIT] |=> bus_16bit == $past(width_s);
  endproperty
  a_width_dyn: assert property (p_width_dyn) else $error("bus width not following pin"); // [R9]

  property p_pd_gate;
    power_down_enter |-> $past(q.chip_configuration[CCR_PD_BIT]) && $past(q.pd_req);
  endproperty
  a_pd_gate: assert property (p_pd_gate) else $error("power-down entered while gated"); // [R7]

  property p_pulldown;
    clk_en && q.state == BCAM_ST_RUN && !pin_n_s |=> reset_pin_oe [*8];
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down released early"); // [R11]

  property p_ccr_hold;
    q.state == BCAM_ST_RUN |=> $stable(q.chip_configuration);
  endproperty
  a_ccr_hold: assert property (p_ccr_hold) else $error("configuration changed in run"); // [R20]

  property p_ready_cap;
    clk_en && q.run && wait_phase && !q.ready && q.wait_cnt >= limit_c |=> cycle_ready;
  endproperty
  a_ready_cap: assert property (p_ready_cap) else $error("wait ceiling exceeded"); // [R4]

  property p_ram_decode;
    clk_en && cpu_addr >= MAP_RAM_LO && cpu_addr < MAP_EXTL_LO
      |=> addr_region == BCAM_RGN_RAM && !addr_external;
  endproperty
  a_ram_decode: assert property (p_ram_decode) else $error("RAM range decoded wrong"); // [R13]

  property p_cfg_wide;
    $rose(cfg_rd_req) |-> cfg_rd_wide == $past(width_s);
  endproperty
  a_cfg_wide: assert property (p_cfg_wide) else $error("config read width wrong"); // [R2]

  property p_pd_block;
    clk_en && !q.chip_configuration[CCR_PD_BIT] |=> !power_down_enter;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("power-down not blocked"); // [R7]

  property p_hold_idle;
    clk_en && !hold_ack && bus_busy |=> !hold_ack;
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("hold granted while busy"); // [R19]

endmodule

// ===== bcam_pkg.sv
// constants and types shared by the boot configuration block
package bcam_pkg;

  // fixed boot addresses
  localparam logic [15:0] CFG_BYTE_ADDR    = 16'h2018;
  localparam logic [15:0] FIRST_FETCH_ADDR = 16'h2080;

  // chip_configuration field positions
  localparam int unsigned CCR_PD_BIT   = 0;
  localparam int unsigned CCR_DYN_BIT  = 1;
  localparam int unsigned CCR_WR_BIT   = 2;
  localparam int unsigned CCR_ADV_BIT  = 3;
  localparam int unsigned CCR_IRC_LO   = 4;
  localparam int unsigned CCR_IRC_HI   = 5;
  localparam logic [7:0]  CCR_USED_MASK = 8'h3F;
  localparam logic [7:0]  CCR_RESET     = 8'h00;

  // address map boundaries
  localparam logic [15:0] MAP_RAM_LO   = 16'h001A;
  localparam logic [15:0] MAP_EXTL_LO  = 16'h0400;
  localparam logic [15:0] MAP_VECL_LO  = 16'h2000;
  localparam logic [15:0] MAP_RSV1_LO  = 16'h2014;
  localparam logic [15:0] MAP_RSV2_LO  = 16'h2019;
  localparam logic [15:0] MAP_VECU_LO  = 16'h2030;
  localparam logic [15:0] MAP_XFER_LO  = 16'h2040;
  localparam logic [15:0] MAP_RSV3_LO  = 16'h205E;
  localparam logic [15:0] MAP_EXTH_LO  = 16'h2080;

  // register port offsets and fields
  localparam int unsigned    REG_AW       = 4;
  localparam logic [3:0]     REG_CHIP_CFG = 4'h0;
  localparam logic [3:0]     REG_STATUS   = 4'h1;
  localparam logic [3:0]     REG_CONTROL  = 4'h2;
  localparam int unsigned    CTL_PD_REQ   = 0;
  localparam int unsigned    STS_LOADED   = 0;
  localparam int unsigned    STS_BUS16    = 1;
  localparam int unsigned    STS_HOLD     = 2;
  localparam int unsigned    STS_PD       = 3;

  // timing: one state time, counted in clock cycles
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned STATE_TIME_NS   = 20;
  localparam int unsigned PULLDOWN_STATES = 16;
  localparam int unsigned STATE_CYCLES    =
    (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULLDOWN_CYCLES = PULLDOWN_STATES * STATE_CYCLES;
  localparam int unsigned CNT_W           = 8;

  // wait-state ceilings per ready-mode field value
  localparam logic [3:0] RDY_LIMIT0 = 4'h1;
  localparam logic [3:0] RDY_LIMIT1 = 4'h2;
  localparam logic [3:0] RDY_LIMIT2 = 4'h3;
  localparam logic [3:0] RDY_LIMIT3 = 4'hF;

  typedef enum logic [3:0] {
    BCAM_RGN_SFR, BCAM_RGN_RAM, BCAM_RGN_EXT_LO, BCAM_RGN_VEC_LO,
    BCAM_RGN_CFG, BCAM_RGN_VEC_UP, BCAM_RGN_XFER, BCAM_RGN_RSV,
    BCAM_RGN_EXT_HI
  } bcam_region_t;

endpackage

// ===== bcam_sync.sv
// two-flop synchroniser with clock enable
`timescale 1ns/1ps
module bcam_sync #(
  parameter int unsigned WIDTH   = 1,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } bcam_sync_st_t;

  bcam_sync_st_t q, d;

  // first stage only feeds the second
  always_comb begin
    d = q;
    if (clk_en) begin
      d.s1 = din;
      d.s2 = q.s1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= {(2*WIDTH){RST_VAL}};
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule

// ===== bcam_decode.sv
// top-level address map decode
`timescale 1ns/1ps
module bcam_decode
  import bcam_pkg::*;
(
  input  wire logic [15:0] addr,
  output bcam_region_t     region
);
  // ordered range compare, highest boundary first
  always_comb begin
    if (addr >= MAP_EXTH_LO) begin
      region = BCAM_RGN_EXT_HI;   // [R18]
    end else if (addr >= MAP_RSV3_LO) begin
      region = BCAM_RGN_RSV;      // [R17]
    end else if (addr >= MAP_XFER_LO) begin
      region = BCAM_RGN_XFER;     // [R16]
    end else if (addr >= MAP_VECU_LO) begin
      region = BCAM_RGN_VEC_UP;   // [R16]
    end else if (addr >= MAP_RSV2_LO) begin
      region = BCAM_RGN_RSV;
    end else if (addr == CFG_BYTE_ADDR) begin
      region = BCAM_RGN_CFG;
    end else if (addr >= MAP_RSV1_LO) begin
      region = BCAM_RGN_RSV;
    end else if (addr >= MAP_VECL_LO) begin
      region = BCAM_RGN_VEC_LO;   // [R15]
    end else if (addr >= MAP_EXTL_LO) begin
      region = BCAM_RGN_EXT_LO;   // [R14]
    end else if (addr >= MAP_RAM_LO) begin
      region = BCAM_RGN_RAM;      // [R13]
    end else begin
      region = BCAM_RGN_SFR;
    end
  end
endmodule

// ===== bcam_mem_model.sv
// external memory model answering the configuration byte read
`timescale 1ns/1ps
module bcam_mem_model (
  input  wire logic        clk,
  input  wire logic        cfg_rd_req,
  input  wire logic [15:0] cfg_rd_addr,
  input  wire logic        cfg_rd_wide,
  input  wire logic [7:0]  cfg_byte,
  input  wire logic [3:0]  latency,
  output logic             cfg_rd_ack,
  output logic      [15:0] cfg_rd_data
);
  logic [3:0] cnt_q;
  logic       done_q;
  initial begin
    cfg_rd_ack = 1'b0;
    cfg_rd_data = 16'h5A5A;
    cnt_q = 4'h0;
    done_q = 1'b0;
  end
  // answer after the chosen latency, then idle until the request drops
  always @(posedge clk) begin
    if (cfg_rd_ack) begin
      cfg_rd_ack <= 1'b0;
      cfg_rd_data <= ~cfg_rd_data;
    end else if (cfg_rd_req && !done_q && cfg_rd_addr == 16'h2018) begin
      if (cnt_q >= latency) begin
        cfg_rd_ack <= 1'b1;
        done_q <= 1'b1;
        cnt_q <= 4'h0;
        // narrow read leaves the upper lines undriven
        cfg_rd_data <= {cfg_rd_wide ? 8'hC3 : ~cfg_rd_data[15:8], cfg_byte};
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else begin
      cfg_rd_data <= ~cfg_rd_data; // released bus shows a changing pattern
      if (!cfg_rd_req) done_q <= 1'b0;
    end
  end
endmodule

// ===== tb_top.sv
// self-checking testbench for the boot configuration block
`timescale 1ns/1ps
module tb_top
  import bcam_pkg::*;
;
  logic clk, resetn, reg_we, reg_re, wpin, ready_pin, hold_pin, ext_low, bus_busy, wait_phase;
  logic [3:0]  reg_addr, lat;
  logic [7:0]  reg_wdata, reg_rdata, cfg, rd;
  logic [15:0] cpu_addr, cfg_rd_addr, cfg_rd_data, first_fetch_addr;
  logic cfg_rd_req, cfg_rd_wide, cfg_rd_ack, first_fetch, cycle_ready, hold_ack, bus_16bit;
  logic address_strobe_pin, write_strobe_split, power_down_enter, running, addr_external;
  logic addr_reserved, reset_pin_out, reset_pin_oe, pin_n;
  bcam_region_t addr_region;
  int errors, num_checks, n, off;
  logic [15:0] corners [18] = '{16'h0019, 16'h001A, 16'h03FF, 16'h0400, 16'h1FFF, 16'h2000,
    16'h2013, 16'h2014, 16'h2018, 16'h2019, 16'h2030, 16'h203F, 16'h2040, 16'h205D,
    16'h205E, 16'h207F, 16'h2080, 16'hFFFF};

  // open-drain reset wire
  assign pin_n = ~(ext_low | (reset_pin_oe & ~reset_pin_out));

  bcam_top i_bcam_top (.clk(clk), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .reset_pin_n_in(pin_n), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .width_select_pin(wpin), .ready_pin(ready_pin), .hold_pin(hold_pin),
    .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_wide(cfg_rd_wide),
    .cfg_rd_ack(cfg_rd_ack), .cfg_rd_data(cfg_rd_data), .first_fetch(first_fetch),
    .first_fetch_addr(first_fetch_addr), .bus_busy(bus_busy), .wait_phase(wait_phase),
    .cycle_ready(cycle_ready), .hold_ack(hold_ack), .bus_16bit(bus_16bit),
    .address_strobe_pin(address_strobe_pin), .write_strobe_split(write_strobe_split),
    .power_down_enter(power_down_enter), .running(running), .cpu_addr(cpu_addr),
    .addr_region(addr_region), .addr_external(addr_external), .addr_reserved(addr_reserved));

  bcam_mem_model i_bcam_mem_model (.clk(clk), .cfg_rd_req(cfg_rd_req),
    .cfg_rd_addr(cfg_rd_addr), .cfg_rd_wide(cfg_rd_wide), .cfg_byte(cfg), .latency(lat),
    .cfg_rd_ack(cfg_rd_ack), .cfg_rd_data(cfg_rd_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // register port cycles
  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_re <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // expected region of an address
  function automatic bcam_region_t exp_rgn(logic [15:0] a);
    if (a < 16'h001A) return BCAM_RGN_SFR;
    if (a < 16'h0400) return BCAM_RGN_RAM;
    if (a < 16'h2000) return BCAM_RGN_EXT_LO;
    if (a < 16'h2014) return BCAM_RGN_VEC_LO;
    if (a == 16'h2018) return BCAM_RGN_CFG;
    if (a >= 16'h2030 && a < 16'h2040) return BCAM_RGN_VEC_UP;
    if (a >= 16'h2040 && a < 16'h205E) return BCAM_RGN_XFER;
    if (a >= 16'h2080) return BCAM_RGN_EXT_HI;
    return BCAM_RGN_RSV;
  endfunction
  function automatic int lim_of(logic [1:0] f);
    return int'(f == 2'd0 ? RDY_LIMIT0 : f == 2'd1 ? RDY_LIMIT1 :
                f == 2'd2 ? RDY_LIMIT2 : RDY_LIMIT3);
  endfunction

  // follow one configuration fetch and check the modes it sets
  task automatic boot();
    for (n = 0; n < 100 && cfg_rd_req !== 1'b1; n++) tick();
    chk("cfg_rd_addr", CFG_BYTE_ADDR, cfg_rd_addr);
    chk("cfg_rd_wide", {15'h0, wpin}, {15'h0, cfg_rd_wide});
    for (n = 0; n < 100 && first_fetch !== 1'b1; n++) tick();
    chk("first_fetch", 16'h1, {15'h0, first_fetch});
    chk("first_fetch_addr", FIRST_FETCH_ADDR, first_fetch_addr);
    tick();
    tick();
    chk("running", 16'h1, {15'h0, running});
    chk("bus_16bit", {15'h0, cfg[1] & wpin}, {15'h0, bus_16bit});
    chk("address_strobe_pin", {15'h0, cfg[3]}, {15'h0, address_strobe_pin});
    chk("write_strobe_split", {15'h0, cfg[2]}, {15'h0, write_strobe_split});
    reg_rd(REG_CHIP_CFG, rd);
    chk("chip_configuration", {8'h0, cfg & 8'h3F}, {8'h0, rd});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(89));
    {reg_we, reg_re, ready_pin, hold_pin, ext_low, bus_busy, wait_phase} = '0;
    reg_addr = 4'h0; reg_wdata = 8'h00; cpu_addr = 16'h0000;
    cfg = 8'hC0 | 8'($urandom % 16); wpin = 1'b1; lat = 4'h0; resetn = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      if (f > 0) begin
        cfg <= {2'($urandom), 2'(f), 2'($urandom), f[1], f[0]}; // width and power-down sweep
        wpin <= 1'($urandom);
        lat <= 4'($urandom % 7);
        @(posedge clk);
        ext_low <= 1'b1;
        @(posedge clk);
        ext_low <= 1'b0;
        for (n = 0; n < 10 && reset_pin_oe !== 1'b1; n++) tick();
        for (n = 0; n < 60 && reset_pin_oe === 1'b1; n++) tick();
        chk("pulldown_cycles", 16'(PULLDOWN_CYCLES), 16'(n));
        chk("reset_pin_out", 16'h0, {15'h0, reset_pin_out});
      end
      boot();
      // ceiling on ready-inserted waits, ready held low
      @(posedge clk);
      wait_phase <= 1'b1;
      for (n = 0; n < 40 && cycle_ready !== 1'b1; n++) tick();
      @(posedge clk);
      wait_phase <= 1'b0;
      off = n - lim_of(2'(f));
      chk("wait_offset", 16'h1, {15'h0, off == 1});
      chk("wait_cycles", 16'(lim_of(2'(f)) + 1), 16'(n));
      // power-down request gated by the configuration
      reg_wr(REG_CONTROL, 8'h01);
      repeat (3) tick();
      chk("power_down_enter", {15'h0, cfg[0]}, {15'h0, power_down_enter});
      reg_wr(REG_CONTROL, 8'h00);
      // width pin flipped while running
      @(posedge clk);
      wpin <= ~wpin;
      repeat (5) tick();
      chk("bus_16bit_dyn", {15'h0, cfg[1] & wpin}, {15'h0, bus_16bit});
      // memory content and write attempts do not disturb the latched byte
      cfg <= ~cfg;
      reg_wr(REG_CHIP_CFG, 8'hFF);
      reg_rd(REG_CHIP_CFG, rd);
      chk("chip_cfg_held", {8'h0, ~cfg & 8'h3F}, {8'h0, rd});
      $display("test boot %0d done", f);
    end
    // ready arriving early ends the wait well before the longest ceiling
    @(posedge clk);
    ready_pin <= 1'b1;
    wait_phase <= 1'b1;
    for (n = 0; n < 40 && cycle_ready !== 1'b1; n++) tick();
    @(posedge clk);
    wait_phase <= 1'b0;
    ready_pin <= 1'b0;
    chk("ready_early", 16'h1, {15'h0, n < 8});
    // hold handshake
    @(posedge clk);
    hold_pin <= 1'b1;
    bus_busy <= 1'b1;
    repeat (5) tick();
    chk("hold_while_busy", 16'h0, {15'h0, hold_ack});
    bus_busy <= 1'b0;
    for (n = 0; n < 10 && hold_ack !== 1'b1; n++) tick();
    chk("hold_ack", 16'h1, {15'h0, hold_ack});
    reg_rd(REG_STATUS, rd);
    chk("status_hold", 16'h1, {15'h0, rd[STS_HOLD]});
    hold_pin <= 1'b0;
    for (n = 0; n < 10 && hold_ack !== 1'b0; n++) tick();
    chk("hold_release", 16'h0, {15'h0, hold_ack});
    reg_rd(4'hF, rd);
    chk("unmapped", 16'h0, {8'h0, rd});
    $display("test ready and hold done");
    // address map: corners then random addresses
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      cpu_addr <= (i < 18) ? corners[i] : 16'($urandom);
      tick();
      tick();
      chk("addr_region", 16'(exp_rgn(cpu_addr)), 16'(addr_region));
      chk("addr_reserved", {15'h0, exp_rgn(cpu_addr) == BCAM_RGN_RSV},
          {15'h0, addr_reserved});
      if (exp_rgn(cpu_addr) inside {BCAM_RGN_EXT_LO, BCAM_RGN_EXT_HI, BCAM_RGN_RAM})
        chk("addr_external", {15'h0, exp_rgn(cpu_addr) != BCAM_RGN_RAM},
            {15'h0, addr_external});
    end
    $display("test address map done");
    report_and_stop();
  end
endmodule
